// ---- design/ltc_core.sv ----
/*
 * lin transceiver mode control core plus its transmit-path fifo.
 * assumes pins and front-end indicators arrive asynchronously (synchronised
 * here), one 25 MHz clock, synchronous active-low reset released after supply rise.
 */
// Function
// - enable high means normal mode, paths active; in sleep the code ignores enable and only a wake-up, to fail-safe, or supply loss, to unpowered, leaves it
// - enable falls with txd high: sleep
// - power-up enters fail-safe, inhibit on
// - undervoltage disables transmission
// - txd low dominant, txd high recessive
// - txd low at entry: wait high 10us
// - fail-safe: txd pin becomes source output
// - txd low over 20ms forces recessive
// - after time-out, re-arm after 10us high
// - sleep decision uses present txd level
// - normal mode: rxd follows bus level
// - unpowered: rxd not driven
// - floating enable counts as low
// - inhibit on normal/fail-safe, off sleep
// - wake-up switches inhibit on
// - bus wake needs 100us dominant
// - local wake needs 100us low
// - over-temperature clear re-enables driver
// - sleep allowed with bus shorted low
// - fail-safe source coding on txd/rxd
// - fail-safe until enable high with no undervoltage, then normal
// - wake sources cleared on reaching normal
// - undervoltage in normal goes to fail-safe
`timescale 1ns/1ps

module ltc_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // flip-flop storage
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic do_wr, do_rd;

    // handshakes straight from the fill level
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // next pointer and level
    always_comb begin
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    // register pointers and write storage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : ltc_fifo

module ltc_core
    import ltc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host side pins
    input wire logic enable_in,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    output logic rxd_out,
    output logic rxd_oe,
    // bus side
    input wire logic bus_in,
    output logic bus_drive_dominant,
    // local wake and supply indicators
    input wire logic local_wake_in,
    input wire ltc_supply_t battery_supply,
    // regulator control and status
    output logic regulator_inhibit_out,
    output ltc_mode_t mode,
    // transmit path stall indication
    output logic tx_fifo_ready
);

    // synchroniser stages
    logic [5:0] sync1, sync2;
    logic en_s, txd_s, bus_s, wk_s, ok_s, uv_s, ot_s;

    // mode machine state
    ltc_mode_t next_mode;
    ltc_src_t src, next_src;
    logic en_prev, next_en_prev;

    // timers and driver gate
    logic [CNT_W-1:0] dom_cnt, next_dom_cnt;
    logic [CNT_W-1:0] rearm_cnt, next_rearm_cnt;
    logic [CNT_W-1:0] bwk_cnt, next_bwk_cnt;
    logic [CNT_W-1:0] lwk_cnt, next_lwk_cnt;
    logic drv_armed, next_drv_armed;
    logic lwk_hi, next_lwk_hi;
    logic bus_wake, local_wake;

    // fifo feed and drain
    ltc_tx_word_t fifo_in, fifo_out;
    logic fifo_out_valid;
    logic next_drive, next_rxd, next_txd_oe, next_txd_out, next_rxd_oe;

    // counts while a condition holds, saturating at the limit
    function automatic logic [CNT_W-1:0] hold_count(input logic cond, input logic [CNT_W-1:0] cnt,
                                                     input logic [CNT_W-1:0] lim);
        if (!cond) begin
            hold_count = CNT_ZERO;
        end else if (cnt < lim) begin
            hold_count = cnt + CNT_ONE;
        end else begin
            hold_count = cnt;
        end
    endfunction : hold_count

    // two-flop synchronisers for every asynchronous input
    always_ff @(posedge ref_clk) begin
        sync1 <= {enable_in, txd_in, bus_in, local_wake_in, battery_supply.supply_ok, battery_supply.undervoltage};
        sync2 <= sync1;
    end

    // over-temperature synchroniser kept separate from the packed group
    logic ot1, ot2;
    always_ff @(posedge ref_clk) begin
        ot1 <= battery_supply.over_temp;
        ot2 <= ot1;
    end

    // an unknown or floating enable resolves low after the synchroniser
    assign en_s = (sync2[5] === 1'b1);
    assign txd_s = sync2[4];
    assign bus_s = sync2[3];
    assign wk_s = sync2[2];
    assign ok_s = sync2[1];
    assign uv_s = sync2[0];
    assign ot_s = ot2;

    // wake filters only counted in sleep mode
    assign bus_wake = (bwk_cnt == CNT_W'(WAKE_CYC)) && bus_s;      // dominant then release
    assign local_wake = (lwk_cnt == CNT_W'(WAKE_CYC));

    // timers next values
    always_comb begin
        // dominant time-out counts while host holds txd low in normal mode
        next_dom_cnt = hold_count(mode == LTC_NORMAL && !txd_s, dom_cnt, CNT_W'(DOM_CYC));
        // re-arm counter counts txd high time
        next_rearm_cnt = hold_count(txd_s, rearm_cnt, CNT_W'(REARM_CYC));
        // bus dominant time, kept through the rising edge that completes the wake
        if (mode != LTC_SLEEP) begin
            next_bwk_cnt = CNT_ZERO;
        end else if (!bus_s) begin
            next_bwk_cnt = hold_count(1'b1, bwk_cnt, CNT_W'(WAKE_CYC));
        end else if (bwk_cnt == CNT_W'(WAKE_CYC)) begin
            next_bwk_cnt = bwk_cnt;
        end else begin
            next_bwk_cnt = CNT_ZERO;
        end
        // local wake needs a high phase before a low edge starts a request
        next_lwk_hi = (mode == LTC_SLEEP) ? (lwk_hi || wk_s) : wk_s;
        next_lwk_cnt = hold_count(mode == LTC_SLEEP && lwk_hi && !wk_s, lwk_cnt, CNT_W'(WAKE_CYC));
        // driver gate: disarmed outside normal mode or on time-out; re-armed by txd high 10us while not over-temperature
        next_drv_armed = drv_armed;
        if (mode != LTC_NORMAL || dom_cnt == CNT_W'(DOM_CYC)) begin
            next_drv_armed = 1'b0;
        end else if (rearm_cnt == CNT_W'(REARM_CYC) && !ot_s) begin
            next_drv_armed = 1'b1;
        end
    end

    // mode machine next values
    always_comb begin
        next_mode = mode;
        next_src = src;
        next_en_prev = en_s;
        if (!ok_s) begin
            next_mode = LTC_UNPOWERED;
            next_src = LTC_SRC_NONE;
        end else begin
            case (mode)
                LTC_UNPOWERED: begin
                    next_mode = LTC_FAILSAFE;
                    next_src = uv_s ? LTC_SRC_UNDERVOLT : LTC_SRC_NONE;
                end
                LTC_FAILSAFE: begin
                    if (en_s && !uv_s) begin
                        next_mode = LTC_NORMAL;
                        next_src = LTC_SRC_NONE;
                    end else if (en_prev && !en_s && txd_s) begin
                        next_mode = LTC_SLEEP;
                    end
                end
                LTC_NORMAL: begin
                    if (uv_s) begin
                        next_mode = LTC_FAILSAFE;
                        next_src = LTC_SRC_UNDERVOLT;
                    end else if (!en_s && txd_s) begin
                        next_mode = LTC_SLEEP;
                    end
                end
                LTC_SLEEP: begin
                    if (bus_wake) begin
                        next_mode = LTC_FAILSAFE;
                        next_src = LTC_SRC_BUS_WAKE;
                    end else if (local_wake) begin
                        next_mode = LTC_FAILSAFE;
                        next_src = LTC_SRC_LOCAL_WAKE;
                    end
                end
                default: next_mode = LTC_UNPOWERED;
            endcase
        end
    end

    // fifo sample: host level and gate, taken each cycle in normal mode
    assign fifo_in.tx_level = txd_s;
    assign fifo_in.drv_allow = drv_armed && !uv_s && !ot_s;

    ltc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) i_ltc_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n && mode == LTC_NORMAL),
        .in_data(fifo_in),
        .in_valid(mode == LTC_NORMAL),
        .in_ready(tx_fifo_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );

    // pin outputs next values
    always_comb begin
        next_drive = 1'b0;
        next_rxd = 1'b1;
        next_rxd_oe = 1'b1;
        next_txd_oe = 1'b0;
        next_txd_out = 1'b1;
        case (mode)
            LTC_NORMAL: begin
                // low txd drives dominant only through the armed gate
                next_drive = fifo_out_valid && fifo_out.drv_allow && !fifo_out.tx_level;
                next_rxd = bus_s;
            end
            LTC_FAILSAFE: begin
                next_txd_oe = 1'b1;
                case (src)
                    LTC_SRC_BUS_WAKE: begin
                        next_txd_out = 1'b0;
                        next_rxd = 1'b0;
                    end
                    LTC_SRC_LOCAL_WAKE: begin
                        next_txd_out = 1'b0;
                        next_rxd = 1'b1;
                    end
                    LTC_SRC_UNDERVOLT: begin
                        next_txd_out = 1'b1;
                        next_rxd = 1'b0;
                    end
                    default: begin
                        next_txd_out = 1'b1;
                        next_rxd = 1'b1;
                    end
                endcase
            end
            LTC_SLEEP: next_rxd_oe = 1'b0;
            default: next_rxd_oe = 1'b0;
        endcase
    end

    // register all state and outputs
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode <= LTC_UNPOWERED;
            src <= LTC_SRC_NONE;
            en_prev <= 1'b0;
            dom_cnt <= CNT_ZERO;
            rearm_cnt <= CNT_ZERO;
            bwk_cnt <= CNT_ZERO;
            lwk_cnt <= CNT_ZERO;
            lwk_hi <= 1'b0;
            drv_armed <= 1'b0;
            bus_drive_dominant <= 1'b0;
            rxd_out <= 1'b1;
            rxd_oe <= 1'b0;
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            regulator_inhibit_out <= 1'b0;
        end else begin
            mode <= next_mode;
            src <= next_src;
            en_prev <= next_en_prev;
            dom_cnt <= next_dom_cnt;
            rearm_cnt <= next_rearm_cnt;
            bwk_cnt <= next_bwk_cnt;
            lwk_cnt <= next_lwk_cnt;
            lwk_hi <= next_lwk_hi;
            drv_armed <= next_drv_armed;
            bus_drive_dominant <= next_drive;
            rxd_out <= next_rxd;
            rxd_oe <= next_rxd_oe;
            txd_out <= next_txd_out;
            txd_oe <= next_txd_oe;
            // inhibit follows the next mode so a wake turns it on with the mode change
            regulator_inhibit_out <= (next_mode == LTC_NORMAL || next_mode == LTC_FAILSAFE);
        end
    end

endmodule : ltc_core

// ---- design/ltc_pkg.sv ----
/*
 * package for the lin transceiver mode control core: modes, fail-safe sources,
 * timing constants and carrier structs.
 * assumes a 25 MHz ref_clk shared by every file that imports it.
 */
package ltc_pkg;

    // clock rate
    localparam int CLK_HZ = 25000000;
    localparam int CLK_NS = 40;

    // documented times in their own units
    localparam int REARM_US = 10;       // txd high time to re-arm driver
    localparam int DOM_TIMEOUT_MS = 20; // dominant time-out
    localparam int WAKE_FILT_US = 100;  // wake filter time

    // derived cycle counts (least times round up)
    localparam int REARM_CYC = (REARM_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (WAKE_FILT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int DOM_CYC = (DOM_TIMEOUT_MS * 1000 + CLK_NS - 1) / CLK_NS * 1000;

    // counter width, large enough for the dominant time-out
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

    // fifo geometry
    localparam int FIFO_W = 2;
    localparam int FIFO_D = 16;

    // operating modes
    typedef enum logic [1:0] {
        LTC_UNPOWERED,
        LTC_FAILSAFE,
        LTC_NORMAL,
        LTC_SLEEP
    } ltc_mode_t;

    // cause of the current fail-safe stay
    typedef enum logic [1:0] {
        LTC_SRC_NONE,
        LTC_SRC_BUS_WAKE,
        LTC_SRC_LOCAL_WAKE,
        LTC_SRC_UNDERVOLT
    } ltc_src_t;

    // supply and thermal indicators from the analog front end
    typedef struct packed {
        logic supply_ok;     // supply above operating threshold
        logic undervoltage;  // supply below undervoltage threshold
        logic over_temp;     // thermal shutdown active
    } ltc_supply_t;

    // sample carried through the fifo: host txd level and driver gate
    typedef struct packed {
        logic tx_level;
        logic drv_allow;
    } ltc_tx_word_t;

endpackage : ltc_pkg

// ---- tb/ltc_host_model.sv ----
/*
 * host side model: the protocol handler's enable and txd pins.
 * assumes the bench sets the host's intent and that txd carries an external pull-up.
 */
`timescale 1ns/1ps

module ltc_host_model (
    // host intent from the bench
    input wire logic host_en,
    input wire logic host_en_float,
    input wire logic host_tx_low,
    // core side of the shared txd pin
    input wire logic txd_out,
    input wire logic txd_oe,
    // resolved pins seen by the core
    output logic enable_in,
    output logic txd_in
);
    // enable pin is driven or left floating, no pull on our side
    assign enable_in = host_en_float ? 1'hZ : host_en;
    // txd is wired-and with a pull-up: host pulls low for dominant, core pulls low for its source code
    assign txd_in = (host_tx_low ? 1'h0 : 1'h1) & ((txd_oe && !txd_out) ? 1'h0 : 1'h1);
endmodule : ltc_host_model

// ---- tb/ltc_core_asserts.sv ----
/*
 * checker for the mode control core, bound to the core's ports.
 * assumes a single ref_clk domain and the synchronous active-low reset.
 */
`timescale 1ns/1ps

module ltc_core_asserts
    import ltc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host side pins
    input wire logic enable_in,
    input wire logic txd_in,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    // bus side
    input wire logic bus_in,
    input wire logic bus_drive_dominant,
    // wake and supply
    input wire logic local_wake_in,
    input wire ltc_supply_t battery_supply,
    // status
    input wire logic regulator_inhibit_out,
    input wire ltc_mode_t mode,
    input wire logic tx_fifo_ready
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_inh;
        regulator_inhibit_out == (mode == LTC_NORMAL || mode == LTC_FAILSAFE);
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit does not match mode");
    property p_sleep_quiet;
        mode == LTC_SLEEP && $past(mode) == LTC_SLEEP |-> !bus_drive_dominant && !rxd_oe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");
    property p_unpow;
        mode == LTC_UNPOWERED && $past(mode) == LTC_UNPOWERED |-> !rxd_oe && !txd_oe;
    endproperty
    a_unpow: assert property (p_unpow) else $error("pin driven while unpowered");
    property p_fs_oe;
        mode == LTC_FAILSAFE && $past(mode) == LTC_FAILSAFE |-> txd_oe && rxd_oe;
    endproperty
    a_fs_oe: assert property (p_fs_oe) else $error("source pins not driven in fail-safe");
    property p_normal;
        mode == LTC_NORMAL && $past(mode) == LTC_NORMAL |-> !txd_oe && rxd_oe;
    endproperty
    a_normal: assert property (p_normal) else $error("pin directions wrong in normal");
    property p_rxd;
        (mode == LTC_NORMAL && $stable(bus_in))[*5] |-> rxd_out == bus_in;
    endproperty
    a_rxd: assert property (p_rxd) else $error("rxd does not follow bus");
    property p_en_normal;
        $rose(mode == LTC_NORMAL) |-> $past(enable_in, 2) || $past(enable_in, 3) || $past(enable_in, 4);
    endproperty
    a_en_normal: assert property (p_en_normal) else $error("normal entered without enable");
    property p_uv;
        battery_supply.undervoltage[*6] |-> !bus_drive_dominant;
    endproperty
    a_uv: assert property (p_uv) else $error("driver on during undervoltage");
    property p_txd_hi;
        txd_in[*6] |-> !bus_drive_dominant;
    endproperty
    a_txd_hi: assert property (p_txd_hi) else $error("dominant while txd high");
    property p_armed;
        $rose(mode == LTC_NORMAL) && !txd_in && !$past(txd_in) && !$past(txd_in, 2) && !$past(txd_in, 3)
            |-> !bus_drive_dominant[*8];
    endproperty
    a_armed: assert property (p_armed) else $error("driver active before re-arm");
endmodule : ltc_core_asserts

bind ltc_core ltc_core_asserts i_ltc_core_asserts (
    .ref_clk(ref_clk), .reset_n(reset_n), .enable_in(enable_in), .txd_in(txd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .bus_in(bus_in), .bus_drive_dominant(bus_drive_dominant), .local_wake_in(local_wake_in),
    .battery_supply(battery_supply), .regulator_inhibit_out(regulator_inhibit_out),
    .mode(mode), .tx_fifo_ready(tx_fifo_ready)
);

// ---- tb/ltc_core_tb.sv ----
/*
 * self-checking bench for the mode control core: power-up, normal traffic,
 * sleep with wake-ups, undervoltage.
 * assumes the host model on the pins and a pulled-up bus resolved here.
 */
`timescale 1ns/1ps

module ltc_core_tb
    import ltc_pkg::*;
;
    logic ref_clk = 1'h0; // 25 MHz clock
    logic reset_n = 1'h0; // held low at start
    logic host_en = 1'h0; // host enable intent
    logic host_en_float = 1'h0; // host leaves enable open
    logic host_tx_low = 1'h0; // host pulls txd low
    logic bus_short = 1'h0; // bus shorted to ground
    logic local_wake_in = 1'h1; // wake switch open
    ltc_supply_t battery_supply = 3'h4; // supply ok, no faults
    logic enable_in, txd_in, txd_out, txd_oe, rxd_out, rxd_oe, bus_in, bus_drive_dominant;
    logic regulator_inhibit_out, tx_fifo_ready;
    ltc_mode_t mode;
    int error_cnt = 0;
    int n_checks = 0;

    // clock
    always #20 ref_clk = ~ref_clk;
    // bus has a pull-up; our driver or a short pulls it low
    assign bus_in = (bus_drive_dominant || bus_short) ? 1'h0 : 1'h1;

    ltc_core i_ltc_core (.ref_clk(ref_clk), .reset_n(reset_n), .enable_in(enable_in), .txd_in(txd_in),
        .txd_out(txd_out), .txd_oe(txd_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .bus_in(bus_in),
        .bus_drive_dominant(bus_drive_dominant), .local_wake_in(local_wake_in),
        .battery_supply(battery_supply), .regulator_inhibit_out(regulator_inhibit_out),
        .mode(mode), .tx_fifo_ready(tx_fifo_ready));
    ltc_host_model i_ltc_host_model (.host_en(host_en), .host_en_float(host_en_float),
        .host_tx_low(host_tx_low), .txd_out(txd_out), .txd_oe(txd_oe), .enable_in(enable_in), .txd_in(txd_in));

    // wait n rising edges, then settle on the falling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cyc

    task automatic chk(input string what, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // bounded wait for a mode; running out ends the run
    task automatic wait_mode(input ltc_mode_t m, input int lim);
        int i;
        n_checks++;
        for (i = 0; i < lim && mode !== m; i++) begin
            cyc(1);
        end
        if (mode !== m) begin
            error_cnt++;
            $display("[FAIL] mode expected %s seen %s", m.name(), mode.name());
            print_verdict();
        end
    endtask : wait_mode

    task automatic t_powerup();
        chk("rxd_oe in reset", rxd_oe, 1'h0);
        @(posedge ref_clk);
        reset_n <= 1'h1;
        wait_mode(LTC_FAILSAFE, 10);
        cyc(2);
        chk("inhibit at power-up", regulator_inhibit_out, 1'h1);
        chk("txd_oe fail-safe", txd_oe, 1'h1);
        chk("txd code none", txd_out, 1'h1);
        chk("rxd code none", rxd_out, 1'h1);
    endtask : t_powerup

    task automatic t_normal_arm();
        @(posedge ref_clk);
        host_tx_low <= 1'h1;
        host_en <= 1'h1;
        wait_mode(LTC_NORMAL, 10);
        cyc(2);
        chk("txd released", txd_oe, 1'h0);
        chk("rxd driven", rxd_oe, 1'h1);
        chk("fifo ready", tx_fifo_ready, 1'h1);
        cyc(50);
        chk("held off at entry", bus_drive_dominant, 1'h0);
        @(posedge ref_clk);
        host_tx_low <= 1'h0;
        cyc(REARM_CYC / 2);
        @(posedge ref_clk);
        host_tx_low <= 1'h1;
        cyc(10);
        chk("short high does not arm", bus_drive_dominant, 1'h0);
        @(posedge ref_clk);
        host_tx_low <= 1'h0;
        cyc(REARM_CYC + 10);
        chk("recessive", bus_drive_dominant, 1'h0);
        chk("rxd recessive", rxd_out, 1'h1);
        @(posedge ref_clk);
        host_tx_low <= 1'h1;
        cyc(8);
        chk("dominant", bus_drive_dominant, 1'h1);
        chk("rxd dominant", rxd_out, 1'h0);
        // thermal shutdown while dominant, then cooling restores the driver
        @(posedge ref_clk);
        battery_supply.over_temp <= 1'h1;
        cyc(8);
        chk("driver off while hot", bus_drive_dominant, 1'h0);
        chk("rxd high while hot", rxd_out, 1'h1);
        @(posedge ref_clk);
        battery_supply.over_temp <= 1'h0;
        cyc(8);
        chk("driver back after cooling", bus_drive_dominant, 1'h1);
        @(posedge ref_clk);
        host_tx_low <= 1'h0;
        cyc(8);
    endtask : t_normal_arm

    task automatic t_sleep_bus_wake();
        @(posedge ref_clk);
        bus_short <= 1'h1;
        cyc(5);
        @(posedge ref_clk);
        host_en <= 1'h0;
        wait_mode(LTC_SLEEP, 10);
        cyc(2);
        chk("inhibit off asleep", regulator_inhibit_out, 1'h0);
        cyc(WAKE_CYC + 100);
        chk("asleep while shorted", mode === LTC_SLEEP, 1'h1);
        @(posedge ref_clk);
        bus_short <= 1'h0;
        wait_mode(LTC_FAILSAFE, 10);
        cyc(2);
        chk("inhibit on bus wake", regulator_inhibit_out, 1'h1);
        chk("txd code bus wake", txd_out, 1'h0);
        chk("rxd code bus wake", rxd_out, 1'h0);
    endtask : t_sleep_bus_wake

    task automatic t_local_wake();
        @(posedge ref_clk);
        host_en <= 1'h1;
        wait_mode(LTC_NORMAL, 10);
        @(posedge ref_clk);
        local_wake_in <= 1'h0;
        cyc(WAKE_CYC + 50);
        chk("no wake in normal", mode === LTC_NORMAL, 1'h1);
        @(posedge ref_clk);
        local_wake_in <= 1'h1;
        host_en <= 1'h0;
        wait_mode(LTC_SLEEP, 10);
        @(posedge ref_clk);
        local_wake_in <= 1'h0;
        cyc(WAKE_CYC - 10);
        chk("wake not before filter", mode === LTC_SLEEP, 1'h1);
        wait_mode(LTC_FAILSAFE, 40);
        cyc(2);
        chk("inhibit on local wake", regulator_inhibit_out, 1'h1);
        chk("txd code local wake", txd_out, 1'h0);
        chk("rxd code local wake", rxd_out, 1'h1);
        @(posedge ref_clk);
        local_wake_in <= 1'h1;
    endtask : t_local_wake

    task automatic t_undervolt();
        @(posedge ref_clk);
        host_en <= 1'h1;
        wait_mode(LTC_NORMAL, 10);
        // txd was held low by the wake code at entry, so hold it high to re-arm
        cyc(REARM_CYC + 10);
        @(posedge ref_clk);
        host_tx_low <= 1'h1;
        cyc(8);
        chk("dominant before undervoltage", bus_drive_dominant, 1'h1);
        @(posedge ref_clk);
        battery_supply.undervoltage <= 1'h1;
        wait_mode(LTC_FAILSAFE, 10);
        cyc(2);
        chk("driver off in undervoltage", bus_drive_dominant, 1'h0);
        chk("txd code undervoltage", txd_out, 1'h1);
        chk("rxd code undervoltage", rxd_out, 1'h0);
        @(posedge ref_clk);
        host_tx_low <= 1'h0;
        host_en_float <= 1'h1;
        wait_mode(LTC_SLEEP, 10);
        @(posedge ref_clk);
        battery_supply.undervoltage <= 1'h0;
        cyc(5);
        // supply loss goes unpowered, supply return restarts in fail-safe
        @(posedge ref_clk);
        battery_supply.supply_ok <= 1'h0;
        wait_mode(LTC_UNPOWERED, 10);
        cyc(2);
        chk("rxd released unpowered", rxd_oe, 1'h0);
        @(posedge ref_clk);
        battery_supply.supply_ok <= 1'h1;
        wait_mode(LTC_FAILSAFE, 10);
        cyc(2);
        chk("inhibit on supply return", regulator_inhibit_out, 1'h1);
        chk("txd_oe after supply return", txd_oe, 1'h1);
    endtask : t_undervolt

    // main sequence
    initial begin
        cyc(19);
        t_powerup();
        t_normal_arm();
        t_sleep_bus_wake();
        t_local_wake();
        t_undervolt();
        print_verdict();
    end
endmodule : ltc_core_tb
